// ---- mmne_exec.sv ----
// apb-controlled executor for literal load, store, two multiplies and negate
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps

module mmne_exec (
	input wire logic clk_sys_in, // system clock, 250 MHz
	input wire logic reset_n_in, // asynchronous reset, active low
	input wire logic psel_in, // apb select
	input wire logic penable_in, // apb enable
	input wire logic pwrite_in, // apb direction, 1 = write
	input wire logic [7:0] paddr_in, // apb byte address
	input wire logic [31:0] pwdata_in, // apb write data
	output logic [31:0] prdata_out, // apb read data
	output logic pready_out, // apb ready
	output logic pslverr_out, // apb error
	output logic busy_out // instruction in flight
);
	import mmne_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0] file_mem [MEM_DEPTH];
	mmne_phase_t phase;
	mmne_op_t op;
	logic [15:0] instr_word;
	logic [7:0] acc;
	logic [4:0] flags;
	logic [3:0] bank_select_register;
	logic ext_enable;
	logic [11:0] index_base;
	logic [11:0] mem_addr;
	logic [11:0] eff_addr;
	logic [7:0] operand;
	logic [7:0] product_low_byte;
	logic [7:0] product_high_byte;
	logic [15:0] product_q;
	logic [7:0] negate_q;
	logic [4:0] negate_flags_q;
	logic illegal;
	logic [15:0] alu_product;
	logic [7:0] alu_negate;
	logic [4:0] alu_negate_flags;
	logic apb_setup;
	logic apb_access;
	logic apb_wr;
	logic addr_ok;
	logic wr_blocked;

	// ************************************************************
	// apb slave
	// ************************************************************
	assign apb_setup = psel_in && !penable_in;
	assign apb_access = psel_in && penable_in && pready_out;
	assign apb_wr = apb_access && pwrite_in && !pslverr_out;
	// writes while an instruction runs would race the sequencer, so they are refused
	assign wr_blocked = pwrite_in && (phase != PH_IDLE);
	always_comb begin
		unique case (paddr_in)
			REG_CTRL, REG_INSTR, REG_ACC, REG_BANK_SELECT, REG_STATUS, REG_PROD_LOW,
			REG_PROD_HIGH, REG_INDEX_BASE, REG_MEM_ADDR, REG_MEM_DATA: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// one wait-free access: ready and data are set up in the setup cycle
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= apb_setup;
			pslverr_out <= apb_setup && (!addr_ok || wr_blocked);
		end
	end

	// read mux, registered so the bus sees a flop
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (apb_setup && !pwrite_in) begin
			prdata_out <= 32'h0000_0000;
			unique case (paddr_in)
				REG_CTRL: prdata_out[CTRL_EXT_BIT] <= ext_enable;
				REG_INSTR: prdata_out[15:0] <= instr_word;
				REG_ACC: prdata_out[7:0] <= acc;
				REG_BANK_SELECT: prdata_out[3:0] <= bank_select_register;
				REG_STATUS: begin
					prdata_out[4:0] <= flags;
					prdata_out[STATUS_BUSY_BIT] <= (phase != PH_IDLE);
					prdata_out[STATUS_ILLEGAL_BIT] <= illegal;
				end
				REG_PROD_LOW: prdata_out[7:0] <= product_low_byte;
				REG_PROD_HIGH: prdata_out[7:0] <= product_high_byte;
				REG_INDEX_BASE: prdata_out[11:0] <= index_base;
				REG_MEM_ADDR: prdata_out[11:0] <= mem_addr;
				REG_MEM_DATA: prdata_out[7:0] <= file_mem[mem_addr];
				default: prdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// software-owned configuration
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ext_enable <= 1'b0;
			bank_select_register <= BANK_RESET;
			index_base <= INDEX_BASE_RESET;
			mem_addr <= 12'h000;
		end else if (apb_wr) begin
			if (paddr_in == REG_CTRL) ext_enable <= pwdata_in[CTRL_EXT_BIT];
			if (paddr_in == REG_BANK_SELECT) bank_select_register <= pwdata_in[3:0];
			if (paddr_in == REG_INDEX_BASE) index_base <= pwdata_in[11:0];
			if (paddr_in == REG_MEM_ADDR) mem_addr <= pwdata_in[11:0];
		end
	end

	// ************************************************************
	// four-phase sequencer
	// ************************************************************
	// a write to the instruction register launches exactly one instruction
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			phase <= PH_IDLE;
			instr_word <= INSTR_RESET;
		end else begin
			unique case (phase)
				PH_IDLE: begin
					if (apb_wr && paddr_in == REG_INSTR) begin
						instr_word <= pwdata_in[15:0];
						phase <= PH_DECODE;
					end
				end
				PH_DECODE: phase <= PH_READ;
				PH_READ: phase <= PH_PROCESS;
				PH_PROCESS: phase <= PH_WRITE;
				PH_WRITE: phase <= PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy_out <= 1'b0;
		end else begin
			busy_out <= (phase == PH_IDLE) ? (apb_wr && paddr_in == REG_INSTR) : (phase != PH_WRITE);
		end
	end

	// decode phase: opcode and operand address
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			op <= OP_NONE;
			eff_addr <= 12'h000;
			illegal <= 1'b0;
		end else if (phase == PH_DECODE) begin
			op <= mmne_decode(instr_word);
			// 8-bit field indexes a full bank; bank chosen by access bit
			eff_addr <= mmne_eff_addr(instr_word[ACCESS_SEL_BIT], instr_word[7:0], bank_select_register,
				ext_enable, index_base);
			illegal <= (mmne_decode(instr_word) == OP_NONE);
		end
	end

	// read phase: literal or file operand
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			operand <= 8'h00;
		end else if (phase == PH_READ) begin
			if (op == OP_MUL_FILE || op == OP_NEGATE) begin
				operand <= file_mem[eff_addr];
			end else begin
				operand <= instr_word[7:0];
			end
		end
	end

	mmne_alu u_alu (
		.acc_in(acc),
		.operand_in(operand),
		.product_out(alu_product),
		.negate_out(alu_negate),
		.negate_flags_out(alu_negate_flags)
	);

	// process phase: results held until the write phase
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			product_q <= 16'h0000;
			negate_q <= 8'h00;
			negate_flags_q <= FLAGS_RESET;
		end else if (phase == PH_PROCESS) begin
			product_q <= alu_product;
			negate_q <= alu_negate;
			negate_flags_q <= alu_negate_flags;
		end
	end

	// ************************************************************
	// write phase: destinations
	// ************************************************************
	// accumulator: literal load from the core, otherwise software when idle
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			acc <= ACC_RESET;
		end else if (phase == PH_WRITE && op == OP_LOAD_LIT) begin
			acc <= operand;
		end else if (apb_wr && paddr_in == REG_ACC) begin
			acc <= pwdata_in[7:0];
		end
	end

	// only negate touches the flags; load, store and multiplies leave them
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flags <= FLAGS_RESET;
		end else if (phase == PH_WRITE && op == OP_NEGATE) begin
			flags <= negate_flags_q;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			product_low_byte <= 8'h00;
			product_high_byte <= 8'h00;
		end else if (phase == PH_WRITE && (op == OP_MUL_LIT || op == OP_MUL_FILE)) begin
			product_low_byte <= product_q[7:0];
			product_high_byte <= product_q[15:8];
		end
	end

	// data memory: no reset, contents are undefined at power-up
	always_ff @(posedge clk_sys_in) begin
		if (phase == PH_WRITE && op == OP_STORE) begin
			file_mem[eff_addr] <= acc;
		end else if (phase == PH_WRITE && op == OP_NEGATE) begin
			file_mem[eff_addr] <= negate_q;
		end else if (apb_wr && paddr_in == REG_MEM_DATA) begin
			file_mem[mem_addr] <= pwdata_in[7:0];
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	a_load_literal:
	assert property ((phase == PH_WRITE && op == OP_LOAD_LIT) |=> (acc == instr_word[7:0]) && $stable(flags))
		else $error("literal load did not reach accumulator");
	a_decode_load:
	assert property ((phase == PH_DECODE && instr_word[15:8] == 8'h0E) |=> op == OP_LOAD_LIT)
		else $error("literal load decoded wrongly");
	a_decode_store:
	assert property ((phase == PH_DECODE && instr_word[15:9] == 7'h37) |=> op == OP_STORE)
		else $error("store decoded wrongly");
	a_store_write:
	assert property ((phase == PH_WRITE && op == OP_STORE) |=> file_mem[eff_addr] == acc && $stable(flags))
		else $error("store did not write the file register");
	a_banked_addr:
	assert property ((phase == PH_DECODE && instr_word[8]) |=> eff_addr == {$past(bank_select_register),
		$past(instr_word[7:0])})
		else $error("banked address wrong");
	a_indexed_addr:
	assert property ((phase == PH_DECODE && !instr_word[8] && ext_enable && instr_word[7:0] <= 8'h5F)
		|=> eff_addr == 12'($past(index_base) + {4'h0, $past(instr_word[7:0])}))
		else $error("indexed address wrong");
	a_access_addr:
	assert property ((phase == PH_DECODE && !instr_word[8] && !ext_enable)
		|=> eff_addr == (instr_word[7] ? {4'hF, instr_word[7:0]} : {4'h0, instr_word[7:0]}))
		else $error("access bank address wrong");
	a_mul_product:
	assert property ((phase == PH_READ && (op == OP_MUL_LIT || op == OP_MUL_FILE))
		|=> ##2 {product_high_byte, product_low_byte} == {8'h00, acc} * {8'h00, operand})
		else $error("product wrong");
	a_mul_quiet:
	assert property ((phase == PH_WRITE && (op == OP_MUL_LIT || op == OP_MUL_FILE)) |=> $stable(flags) && $stable(acc))
		else $error("multiply touched flags or accumulator");
	a_mul_file_keep:
	assert property ((phase == PH_WRITE && op == OP_MUL_FILE) |=> $stable(file_mem[eff_addr]))
		else $error("file multiply changed its operand");
	a_decode_mul:
	assert property ((phase == PH_DECODE && instr_word[15:9] == 7'h01) |=> op == OP_MUL_FILE)
		else $error("file multiply decoded wrongly");
	a_negate_result:
	assert property ((phase == PH_WRITE && op == OP_NEGATE) |=> file_mem[eff_addr] == 8'(8'h00 - operand)
		&& flags[FLAG_Z_BIT] == (operand == 8'h00) && flags[FLAG_N_BIT] == file_mem[eff_addr][7])
		else $error("negate result or flags wrong");
	a_phase_order:
	assert property ((phase == PH_DECODE) |=> phase == PH_READ ##1 phase == PH_PROCESS ##1 phase == PH_WRITE
		##1 phase == PH_IDLE)
		else $error("phase order broken");

endmodule // mmne_exec

// ---- mmne_pkg.sv ----
// shared constants, types and decode helpers for the move/multiply/negate executor
package mmne_pkg;

	// ************************************************************
	// register map (byte addresses on the apb bus)
	// ************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_INSTR = 8'h04;
	localparam logic [7:0] REG_ACC = 8'h08;
	localparam logic [7:0] REG_BANK_SELECT = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_PROD_LOW = 8'h14;
	localparam logic [7:0] REG_PROD_HIGH = 8'h18;
	localparam logic [7:0] REG_INDEX_BASE = 8'h1C;
	localparam logic [7:0] REG_MEM_ADDR = 8'h20;
	localparam logic [7:0] REG_MEM_DATA = 8'h24;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int CTRL_EXT_BIT = 0;
	localparam int FLAG_C_BIT = 0;
	localparam int FLAG_DC_BIT = 1;
	localparam int FLAG_Z_BIT = 2;
	localparam int FLAG_OV_BIT = 3;
	localparam int FLAG_N_BIT = 4;
	localparam int STATUS_BUSY_BIT = 8;
	localparam int STATUS_ILLEGAL_BIT = 9;
	localparam int ACCESS_SEL_BIT = 8;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [4:0] FLAGS_RESET = 5'h00;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam logic [11:0] INDEX_BASE_RESET = 12'h000;
	localparam logic [15:0] INSTR_RESET = 16'h0000;

	// ************************************************************
	// opcodes and addressing constants
	// ************************************************************
	localparam logic [7:0] OPC_LOAD_LIT = 8'h0E;
	localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
	localparam logic [6:0] OPC_STORE = 7'h37;
	localparam logic [6:0] OPC_NEGATE = 7'h36;
	localparam logic [6:0] OPC_MUL_FILE = 7'h01;
	localparam logic [7:0] INDEX_LIMIT = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	localparam int MEM_DEPTH = 4096;

	typedef enum logic [2:0] {OP_NONE, OP_LOAD_LIT, OP_STORE, OP_MUL_LIT, OP_MUL_FILE, OP_NEGATE} mmne_op_t;
	typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} mmne_phase_t;

	// opcode decode, used by the sequencer's decode phase for both op and illegal; the checks compare opcode fields directly
	function automatic mmne_op_t mmne_decode(input logic [15:0] w);
		mmne_op_t op;
		op = OP_NONE;
		if (w[15:8] == OPC_LOAD_LIT) begin
			op = OP_LOAD_LIT;
		end else if (w[15:8] == OPC_MUL_LIT) begin
			op = OP_MUL_LIT;
		end else if (w[15:9] == OPC_STORE) begin
			op = OP_STORE;
		end else if (w[15:9] == OPC_NEGATE) begin
			op = OP_NEGATE;
		end else if (w[15:9] == OPC_MUL_FILE) begin
			op = OP_MUL_FILE;
		end
		return op;
	endfunction

	// file operand address from access bit, file field, bank and index base
	function automatic logic [11:0] mmne_eff_addr(input logic a, input logic [7:0] f, input logic [3:0] bank,
		input logic ext, input logic [11:0] base);
		logic [11:0] addr;
		addr = {4'h0, f};
		if (a) begin
			addr = {bank, f};
		end else if (ext && f <= INDEX_LIMIT) begin
			addr = 12'(base + {4'h0, f});
		end else if (f >= ACCESS_SPLIT) begin
			addr = {ACCESS_HIGH_BANK, f};
		end
		return addr;
	endfunction

endpackage

// ---- mmne_alu.sv ----
// arithmetic unit: unsigned 8x8 product and two's complement negate with flags
`timescale 1ns/100ps

module mmne_alu (
	input wire logic [7:0] acc_in, // accumulator value
	input wire logic [7:0] operand_in, // literal or file operand
	output logic [15:0] product_out, // unsigned product
	output logic [7:0] negate_out, // negated operand
	output logic [4:0] negate_flags_out // n, ov, z, dc, c after negate
);
	import mmne_pkg::*;

	logic [8:0] full_sum;
	logic [4:0] nib_sum;

	// ************************************************************
	// multiply
	// ************************************************************
	// plain unsigned product; no flags come out of this path
	assign product_out = {8'h00, acc_in} * {8'h00, operand_in};

	// ************************************************************
	// negate
	// ************************************************************
	// invert-and-increment so carry and digit carry fall out of the adder
	assign full_sum = {1'b0, ~operand_in} + 9'h001;
	assign nib_sum = {1'b0, ~operand_in[3:0]} + 5'h01;
	assign negate_out = full_sum[7:0];

	// flags packed by position; overflow only for the most negative value
	always_comb begin
		negate_flags_out = FLAGS_RESET;
		negate_flags_out[FLAG_C_BIT] = full_sum[8];
		negate_flags_out[FLAG_DC_BIT] = nib_sum[4];
		negate_flags_out[FLAG_Z_BIT] = (full_sum[7:0] == 8'h00);
		negate_flags_out[FLAG_OV_BIT] = (operand_in == 8'h80);
		negate_flags_out[FLAG_N_BIT] = full_sum[7];
	end

endmodule // mmne_alu

// ---- mmne_exec_tb.sv ----
// self-checking testbench for the move/multiply/negate executor
`timescale 1ns/100ps

module mmne_exec_tb;
	import mmne_pkg::*;

	// ************************************************************
	// clock, reset, bus signals and counters
	// ************************************************************
	logic clk_sys_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0000_0000;
	logic [31:0] prdata_out;
	logic pready_out;
	logic pslverr_out;
	logic busy_out;
	int n_mismatch = 0;
	int n_tests = 0;

	// 250 MHz system clock
	always #2 clk_sys_in = ~clk_sys_in;

	mmne_exec DUT (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .busy_out(busy_out));

	// ************************************************************
	// verdict, comparison and bus tasks
	// ************************************************************
	task automatic conclude();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			n_mismatch++;
		end
	endtask

	// one apb transfer; ready, data and error are all taken at the rising edge that sees ready high
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		int i;
		// a release from the previous transfer is still pending: let one edge pass first
		if (psel_in === 1'b1) begin
			@(posedge clk_sys_in);
		end
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= addr;
		pwdata_in <= wdata;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_sys_in);
			// outputs only move by non-blocking update, so this is the value the edge samples
			if (pready_out === 1'b1) begin
				rdata = prdata_out;
				err = pslverr_out;
				break;
			end
		end
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (i == 50) begin
			n_mismatch++;
			conclude();
		end
	endtask

	task automatic wreg(input logic [7:0] addr, input logic [31:0] data);
		logic [31:0] rd;
		logic err;
		apb(1'b1, addr, data, rd, err);
		check("write error flag", 32'(1'b0), 32'(err));
	endtask

	task automatic rreg(input string name, input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'b0, addr, 32'h0000_0000, rd, err);
		check(name, exp, rd);
	endtask

	// issue an instruction and wait out busy; returns the count of busy cycles seen
	task automatic run(input logic [15:0] instr, output int cycles);
		wreg(REG_INSTR, {16'h0000, instr});
		for (cycles = 0; cycles < 20; cycles++) begin
			@(negedge clk_sys_in);
			if (busy_out === 1'b0) begin
				break;
			end
		end
		@(posedge clk_sys_in);
		if (cycles == 20) begin
			n_mismatch++;
			conclude();
		end
	endtask

	task automatic poke(input logic [11:0] addr, input logic [7:0] data);
		wreg(REG_MEM_ADDR, {20'h0_0000, addr});
		wreg(REG_MEM_DATA, {24'h00_0000, data});
	endtask

	task automatic peek(input string name, input logic [11:0] addr, input logic [7:0] exp);
		wreg(REG_MEM_ADDR, {20'h0_0000, addr});
		rreg(name, REG_MEM_DATA, {24'h00_0000, exp});
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_negate();
		logic [7:0] v [4] = '{8'h3A, 8'h80, 8'h00, 8'h01};
		logic [7:0] r [4] = '{8'hC6, 8'h80, 8'h00, 8'hFF};
		logic [7:0] fl [4] = '{8'h10, 8'h1A, 8'h07, 8'h10};
		int c;
		wreg(REG_CTRL, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			poke(12'h030, v[i]);
			run({OPC_NEGATE, 1'b0, 8'h30}, c);
			peek("negated file", 12'h030, r[i]);
			rreg("negate flags", REG_STATUS, {24'h00_0000, fl[i]});
		end
	endtask

	task automatic t_load();
		int c;
		// flags stand at n only after the last negate
		run({OPC_LOAD_LIT, 8'h5A}, c);
		check("busy cycles", 32'd4, 32'(c));
		rreg("acc after load", REG_ACC, 32'h0000_005A);
		rreg("flags after load", REG_STATUS, 32'h0000_0010);
	endtask

	task automatic t_store();
		logic ex [7] = '{0, 0, 0, 0, 1, 1, 1};
		logic a [7] = '{1, 1, 0, 0, 0, 0, 1};
		logic [3:0] bk [7] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h5};
		logic [7:0] f [7] = '{8'h42, 8'hFF, 8'h10, 8'h90, 8'h5F, 8'h60, 8'h20};
		logic [11:0] ad [7] = '{12'h342, 12'h3FF, 12'h010, 12'hF90, 12'h25F, 12'h060, 12'h520};
		int c;
		wreg(REG_INDEX_BASE, 32'h0000_0200);
		for (int i = 0; i < 7; i++) begin
			wreg(REG_CTRL, {31'h0000_0000, ex[i]});
			wreg(REG_BANK_SELECT, {28'h000_0000, bk[i]});
			run({OPC_LOAD_LIT, 8'hA0 + 8'(i)}, c);
			run({OPC_STORE, a[i], f[i]}, c);
			peek("stored file", ad[i], 8'hA0 + 8'(i));
		end
		rreg("flags after store", REG_STATUS, 32'h0000_0010);
	endtask

	task automatic t_multiply();
		int c;
		wreg(REG_CTRL, 32'h0000_0000);
		run({OPC_LOAD_LIT, 8'hE2}, c);
		run({OPC_MUL_LIT, 8'hC4}, c);
		rreg("product high", REG_PROD_HIGH, 32'h0000_00AD);
		rreg("product low", REG_PROD_LOW, 32'h0000_0008);
		rreg("acc after multiply", REG_ACC, 32'h0000_00E2);
		run({OPC_MUL_LIT, 8'h00}, c);
		rreg("zero product low", REG_PROD_LOW, 32'h0000_0000);
		rreg("flags after zero product", REG_STATUS, 32'h0000_0010);
		wreg(REG_BANK_SELECT, 32'h0000_0001);
		poke(12'h125, 8'hB5);
		run({OPC_LOAD_LIT, 8'hC4}, c);
		run({OPC_MUL_FILE, 1'b1, 8'h25}, c);
		rreg("file product high", REG_PROD_HIGH, 32'h0000_008A);
		rreg("file product low", REG_PROD_LOW, 32'h0000_0094);
		peek("file after multiply", 12'h125, 8'hB5);
		rreg("acc after file multiply", REG_ACC, 32'h0000_00C4);
		rreg("flags after file multiply", REG_STATUS, 32'h0000_0010);
	endtask

	task automatic t_refuse();
		logic [31:0] rd;
		logic err;
		int c;
		apb(1'b0, 8'h40, 32'h0000_0000, rd, err);
		check("unmapped read error", 32'h0000_0001, 32'(err));
		check("unmapped read data", 32'h0000_0000, rd);
		wreg(REG_PROD_LOW, 32'h0000_0055);
		rreg("read-only product low", REG_PROD_LOW, 32'h0000_0094);
		// a write during execution must bounce; a multiply keeps the accumulator, so a leak would show
		wreg(REG_INSTR, {16'h0000, OPC_MUL_LIT, 8'h02});
		apb(1'b1, REG_ACC, 32'h0000_0011, rd, err);
		check("busy write error", 32'h0000_0001, 32'(err));
		rreg("acc after busy write", REG_ACC, 32'h0000_00C4);
		rreg("product low after busy write", REG_PROD_LOW, 32'h0000_0088);
		run({OPC_LOAD_LIT, 8'h77}, c);
		rreg("acc after reload", REG_ACC, 32'h0000_0077);
		run(16'hFFFF, c);
		rreg("illegal status", REG_STATUS, 32'h0000_0210);
		rreg("acc after illegal", REG_ACC, 32'h0000_0077);
		rreg("instruction readback", REG_INSTR, 32'h0000_FFFF);
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (10) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		@(posedge clk_sys_in);
		rreg("acc reset", REG_ACC, 32'h0000_0000);
		rreg("status reset", REG_STATUS, 32'h0000_0000);
		rreg("product high reset", REG_PROD_HIGH, 32'h0000_0000);
		t_negate();
		t_load();
		t_store();
		t_multiply();
		t_refuse();
		conclude();
	end

endmodule // mmne_exec_tb
